//--- bench/hmp_host_model.sv
// Host-side model driving the strobes and shared bus of the memory port
`timescale 1ns/1ps
module hmp_host_model (
    input wire logic mclk,
    input wire logic ackN,
    input wire logic [15:0] devOut,
    input wire logic devOe,
    output logic selN,
    output logic rdN,
    output logic wrN,
    output logic latchEn,
    output logic [15:0] busIn
);
    logic drive;
    logic [15:0] val;
    initial begin
        selN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        latchEn = 1'b0;
        drive = 1'b0;
        val = 16'h0000;
    end
    // Released bus shows the inverse of the last host value
    assign busIn = devOe ? devOut : (drive ? val : ~val);
    // Reads always wait for acknowledge, never a timed short read
    task automatic waitFree();
        int n;
        n = 0;
        @(negedge mclk);
        while (ackN !== 1'b0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic setAddr(input logic [15:0] a);
        waitFree();
        selN = 1'b0;
        latchEn = 1'b1;
        val = a;
        drive = 1'b1;
        @(negedge mclk);
        selN = 1'b1;
        latchEn = 1'b0;
        drive = 1'b0;
    endtask
    task automatic write(input logic [15:0] d, input bit longW, output logic busy);
        int n;
        waitFree();
        selN = 1'b0;
        wrN = 1'b0;
        val = d;
        drive = 1'b1;
        @(negedge mclk);
        busy = ackN;
        if (longW) begin
            @(negedge mclk);
            busy = busy & ackN;
        end
        n = 0;
        while (longW && ackN !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        selN = 1'b1;
        wrN = 1'b1;
        drive = 1'b0;
    endtask
    task automatic read(output logic [15:0] early, output logic [15:0] late,
            output logic [15:0] lead, output logic busy, output logic oeAfter);
        int n;
        waitFree();
        selN = 1'b0;
        rdN = 1'b0;
        @(negedge mclk);
        busy = ackN;
        @(negedge mclk);
        early = busIn;
        late = busIn;
        lead = busIn;
        n = 0;
        while (ackN !== 1'b0 && n < 20) begin
            lead = busIn;
            @(negedge mclk);
            late = busIn;
            n++;
        end
        selN = 1'b1;
        rdN = 1'b1;
        @(negedge mclk);
        oeAfter = devOe;
    endtask
endmodule

//--- bench/hmp_port_tb_top.sv
// Self-checking bench for the host memory port
`timescale 1ns/1ps
module hmp_port_tb_top;
    logic mclk = 1'b0;
    logic rst_n, strap, coreWe, memRvalid, memReq, memWe, memPm, oe, ackN, mode;
    logic selN, rdN, wrN, latchEn, busy, haveLast;
    logic [15:0] busIn, busOut, coreWdata, overlay, lastWord, a, d;
    logic [13:0] memAddr;
    logic [23:0] memWdata, memRdata;
    logic [38:0] expQ[$];
    int errors = 0;
    int nChecks = 0;
    integer seed = 9;
    always #2 mclk = ~mclk;
    hmp_port u_dut (.mclk(mclk), .rst_n(rst_n), .strap_flag_pin_c(strap),
        .port_select_n(selN), .port_read_strobe_n(rdN), .port_write_strobe_n(wrN),
        .port_address_latch(latchEn), .port_addr_data_bus_in(busIn),
        .port_addr_data_bus_out(busOut), .port_addr_data_bus_oe(oe),
        .port_acknowledge_n(ackN), .hostPortMode(mode), .coreRegWe(coreWe),
        .coreRegWdata(coreWdata), .overlayValue(overlay), .memReq(memReq),
        .memWe(memWe), .memPm(memPm), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata), .memRvalid(memRvalid));
    hmp_host_model u_host (.mclk(mclk), .ackN(ackN), .devOut(busOut), .devOe(oe),
        .selN(selN), .rdN(rdN), .wrN(wrN), .latchEn(latchEn), .busIn(busIn));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && nChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic readChk(input logic [15:0] nw, input bit sro, input bit pm2);
        logic [15:0] e, l, ld;
        logic b, o;
        u_host.read(e, l, ld, b, o);
        chk(b, 1'b1);
        chk(o, 1'b0);
        if (haveLast && !pm2) chk(e, lastWord);
        if (pm2) chk(e, nw);
        chk(l, sro ? lastWord : nw);
        chk(ld, sro ? lastWord : nw);
        lastWord = nw;
        haveLast = 1'b1;
    endtask
    // Memory answers each read one cycle later with its own address as data
    always @(negedge mclk) begin
        memRvalid <= memReq === 1'b1 && memWe === 1'b0;
        memRdata <= {10'h000, memAddr};
    end
    always @(negedge mclk) begin
        if (memReq === 1'b1 && memWe === 1'b1) begin
            chk(expQ.size() > 0, 1'b1);
            if (expQ.size() > 0) chk({memPm, memAddr, memWdata}, expQ.pop_front());
        end
    end
    initial begin
        rst_n = 1'b0;
        strap = 1'b1;
        coreWe = 1'b0;
        coreWdata = 16'h0000;
        haveLast = 1'b0;
        lastWord = 16'h0000;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
        chk(ackN, 1'b0);
        chk(oe, 1'b0);
        chk(overlay, 16'h0000);
        chk(mode, 1'b1);
        a = 16'({$random(seed)} % 32'h1000) + 16'h0100;
        u_host.setAddr(a);
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            expQ.push_back({1'b0, 14'(a + 16'(i)), 8'h00, d});
            u_host.write(d, i[0], busy);
            chk(busy, 1'b1);
        end
        u_host.setAddr(a | 16'h4000);
        d = 16'($random(seed));
        expQ.push_back({1'b1, a[13:0], d, ~d[7:0]});
        u_host.write(d, 1'b0, busy);
        u_host.write(~d, 1'b1, busy);
        u_host.setAddr(a);
        for (int i = 0; i < 2; i++) readChk(a + 16'(i), 1'b0, 1'b0);
        // Program word: upper sixteen bits first, then the low byte
        u_host.setAddr(a | 16'h4000);
        readChk({10'h000, a[13:8]}, 1'b0, 1'b0);
        readChk({8'h00, a[7:0]}, 1'b0, 1'b1);
        u_host.setAddr(16'h3FE7);
        expQ.push_back({1'b0, 14'h3FE7, 24'h004000});
        u_host.write(16'h4000, 1'b1, busy);
        repeat (2) @(negedge mclk);
        chk(overlay, 16'h4000);
        u_host.setAddr(a);
        for (int i = 0; i < 2; i++) readChk(a + 16'(i), 1'b1, 1'b0);
        coreWe = 1'b1;
        @(negedge mclk);
        coreWe = 1'b0;
        @(negedge mclk);
        chk(overlay, 16'h0000);
        readChk(a + 16'h0002, 1'b0, 1'b0);
        // Second reset with the strap clear: port must stay inert
        coreWdata = 16'hFFFF;
        coreWe = 1'b1;
        @(negedge mclk);
        coreWe = 1'b0;
        chk(overlay, 16'hFFFF);
        strap = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
        chk(mode, 1'b0);
        chk(overlay, 16'h0000);
        u_host.write(16'h1234, 1'b1, busy);
        chk(busy, 1'b0);
        chk(ackN, 1'b0);
        chk(oe, 1'b0);
        repeat (4) @(negedge mclk);
        chk(expQ.size(), 0);
        end_sim();
    end
    // The sequence needs under two hundred cycles; this limit leaves wide margin
    initial begin
        #40000;
        errors++;
        end_sim();
    end
endmodule

//--- design/hmp_defines.svh
// Offsets, field positions, reset values and timing counts of the host memory port
`ifndef HMP_DEFINES_SVH
`define HMP_DEFINES_SVH

`define HMP_OVERLAY_ADDR 14'h3FE7
`define HMP_OVERLAY_RST 16'h0000
`define HMP_SRO_BIT 14
`define HMP_SPACE_BIT 14

`define HMP_CLK_PERIOD_PS 4000
`define HMP_ACK_BUSY_MAX_NS 10
`define HMP_ACK_BUSY_CYC ((`HMP_ACK_BUSY_MAX_NS * 1000) / `HMP_CLK_PERIOD_PS)
`define HMP_RELEASE_MAX_NS 10
`define HMP_RELEASE_CYC ((`HMP_RELEASE_MAX_NS * 1000) / `HMP_CLK_PERIOD_PS)
`define HMP_HOLD_FULL_TCK 2
`define HMP_HOLD_HALF_TCK 1
`define HMP_WRITE_ACK_TCK_X10 15
`define HMP_WRITE_ACK_CYC ((`HMP_WRITE_ACK_TCK_X10 + 9) / 10)

`endif

//--- design/hmp_pkg.sv
// Types shared by the host memory port
package hmp_pkg;
    typedef enum logic [2:0] {
        HMP_IDLE = 3'b000,
        HMP_RHOLD = 3'b001,
        HMP_RFETCH = 3'b010,
        HMP_RNEW = 3'b011,
        HMP_RWAIT = 3'b100,
        HMP_WRITE = 3'b101,
        HMP_WDONE = 3'b110
    } hmp_state_t;
    typedef logic [15:0] hmp_word_t;
    typedef logic [13:0] hmp_addr_t;
endpackage

//--- design/hmp_port.sv
// Host memory port: strobe handshake, read and write cycles, overlay control register
//
// How it works
// - Overlay bit 14 enables short-read-only mode
// - Core and host write it; reset clears
// - Short-read-only drives previous word until end
// - Read is select plus read strobe low
// - Write is select plus write strobe low
// - Acknowledge goes high soon after start
// - Long read: new data, then acknowledge low
// - Previous word held two clocks, one second-half
// - Bus released soon after read ends
// - Short and long writes both captured correctly
// - Port active only when mode strap set
// - Mode strap latched at reset release
// - Long write acknowledge low after 2 clocks (1.5 rounded up)
`timescale 1ns/1ps
`include "hmp_defines.svh"
module hmp_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic strap_flag_pin_c,
    input wire logic port_select_n,
    input wire logic port_read_strobe_n,
    input wire logic port_write_strobe_n,
    input wire logic port_address_latch,
    input wire logic [15:0] port_addr_data_bus_in,
    output logic [15:0] port_addr_data_bus_out,
    output logic port_addr_data_bus_oe,
    output logic port_acknowledge_n,
    output logic hostPortMode,
    input wire logic coreRegWe,
    input wire logic [15:0] coreRegWdata,
    output logic [15:0] overlayValue,
    output logic memReq,
    output logic memWe,
    output logic memPm,
    output logic [13:0] memAddr,
    output logic [23:0] memWdata,
    input wire logic [23:0] memRdata,
    input wire logic memRvalid
);
    localparam int ACK_BUSY_CYC = `HMP_ACK_BUSY_CYC;
    localparam int RELEASE_CYC = `HMP_RELEASE_CYC;

    logic rstSyncN;
    logic modeC;
    hmp_pkg::hmp_state_t state_q, stateD;
    logic [1:0] cnt_q, cntD;
    logic ackN_q, ackND;
    hmp_pkg::hmp_word_t busOut_q, outD;
    logic busOe_q, oeD;
    hmp_pkg::hmp_word_t prev_q, prevD;
    hmp_pkg::hmp_addr_t addr_q, addrD;
    logic pm_q, pmD;
    logic half_q, halfD;
    logic [7:0] pmLow_q, pmLowD;
    hmp_pkg::hmp_word_t pmHigh_q, pmHighD;
    hmp_pkg::hmp_word_t wrData_q, wrDataD;
    hmp_pkg::hmp_word_t overlay_q, overlayD;
    logic memReq_q, memReqD;
    logic memWe_q, memWeD;
    logic memPm_q, memPmD;
    hmp_pkg::hmp_addr_t memAddr_q, memAddrD;
    logic [23:0] memWdata_q, memWdataD;
    logic modeOut_q;

    hmp_reset_sync resetSync (
        .mclk(mclk),
        .rst_n(rst_n),
        .rstSyncN(rstSyncN)
    );

    hmp_strap_latch strapLatch (
        .mclk(mclk),
        .rstSyncN(rstSyncN),
        .strapPin(strap_flag_pin_c),
        .strapMode(modeC)
    );

    function automatic logic [14:0] hmpAdvance(input hmp_pkg::hmp_addr_t a, input logic pm,
                                               input logic h);
        if (pm && !h) begin
            return {a, 1'b1};
        end
        return {a + 14'h0001, 1'b0};
    endfunction

    // Access decode from the strobes
    wire readActive = !port_select_n && !port_read_strobe_n;
    wire writeActive = !port_select_n && !port_write_strobe_n;
    wire isIdle = state_q == hmp_pkg::HMP_IDLE;
    // New accesses only from idle, the host waits for acknowledge low
    wire readBegin = modeC && isIdle && readActive;
    wire writeBegin = modeC && isIdle && !readActive && writeActive;
    wire latchAddr = modeC && isIdle && !port_select_n && port_address_latch;
    wire shortOnly = overlay_q[`HMP_SRO_BIT];
    wire isPm2 = pm_q && half_q;
    wire isOvl = !pm_q && (addr_q == `HMP_OVERLAY_ADDR);
    wire [1:0] holdLimit = isPm2 ? 2'(`HMP_HOLD_HALF_TCK) : 2'(`HMP_HOLD_FULL_TCK);
    wire holdDone = cnt_q == (holdLimit - 2'd1);
    wire fetchDone = (state_q == hmp_pkg::HMP_RFETCH && memRvalid)
        || (state_q == hmp_pkg::HMP_RHOLD && holdDone && isPm2);
    wire hmp_pkg::hmp_word_t fetchWord = isPm2 ? {8'h00, pmLow_q}
        : pm_q ? memRdata[23:8] : isOvl ? overlay_q : memRdata[15:0];
    wire writeAckDue = cnt_q == 2'(`HMP_WRITE_ACK_CYC - 1);
    wire commitWrite = state_q == hmp_pkg::HMP_WRITE && !writeActive;
    wire [14:0] nextPos = hmpAdvance(addr_q, pm_q, half_q);

    always_comb begin
        stateD = state_q;
        cntD = cnt_q;
        ackND = ackN_q;
        outD = busOut_q;
        oeD = busOe_q && readActive;
        prevD = prev_q;
        addrD = addr_q;
        pmD = pm_q;
        halfD = half_q;
        pmLowD = pmLow_q;
        pmHighD = pmHigh_q;
        wrDataD = writeActive ? port_addr_data_bus_in : wrData_q;
        memReqD = 1'b0;
        memWeD = 1'b0;
        memPmD = memPm_q;
        memAddrD = memAddr_q;
        memWdataD = memWdata_q;
        overlayD = coreRegWe ? coreRegWdata : overlay_q;
        if (latchAddr) begin
            addrD = port_addr_data_bus_in[13:0];
            pmD = port_addr_data_bus_in[`HMP_SPACE_BIT];
            halfD = 1'b0;
        end
        unique case (state_q)
            hmp_pkg::HMP_IDLE: begin
                if (readBegin) begin
                    // Busy, previous word onto the bus
                    stateD = hmp_pkg::HMP_RHOLD;
                    cntD = 2'd0;
                    ackND = 1'b1;
                    oeD = 1'b1;
                    outD = prev_q;
                end else if (writeBegin) begin
                    stateD = hmp_pkg::HMP_WRITE;
                    cntD = 2'd0;
                    ackND = 1'b1;
                end
            end
            hmp_pkg::HMP_RHOLD: begin
                if (!holdDone) begin
                    cntD = cnt_q + 2'd1;
                end else if (!isPm2) begin
                    stateD = hmp_pkg::HMP_RFETCH;
                    memReqD = 1'b1;
                    memPmD = pm_q;
                    memAddrD = addr_q;
                end
            end
            hmp_pkg::HMP_RFETCH: begin
                stateD = hmp_pkg::HMP_RFETCH;
            end
            hmp_pkg::HMP_RNEW: begin
                ackND = 1'b0;
                stateD = readActive ? hmp_pkg::HMP_RWAIT : hmp_pkg::HMP_IDLE;
            end
            hmp_pkg::HMP_RWAIT: begin
                if (!readActive) begin
                    stateD = hmp_pkg::HMP_IDLE;
                end
            end
            hmp_pkg::HMP_WRITE: begin
                // Acknowledge low no sooner than 1.5 clocks
                if (writeAckDue) begin
                    ackND = 1'b0;
                end else begin
                    cntD = cnt_q + 2'd1;
                end
                if (!writeActive) begin
                    stateD = writeAckDue ? hmp_pkg::HMP_IDLE : hmp_pkg::HMP_WDONE;
                end
            end
            hmp_pkg::HMP_WDONE: begin
                if (writeAckDue) begin
                    ackND = 1'b0;
                    stateD = hmp_pkg::HMP_IDLE;
                end else begin
                    cntD = cnt_q + 2'd1;
                end
            end
            default: begin
                stateD = hmp_pkg::HMP_IDLE;
                ackND = 1'b0;
            end
        endcase
        if (fetchDone) begin
            prevD = fetchWord;
            {addrD, halfD} = nextPos;
            if (pm_q && !half_q) begin
                pmLowD = memRdata[7:0];
            end
            if (readActive && !shortOnly) begin
                outD = fetchWord;
                stateD = hmp_pkg::HMP_RNEW;
            end else begin
                // Read already over or short-read-only: free the port
                ackND = 1'b0;
                stateD = readActive ? hmp_pkg::HMP_RWAIT : hmp_pkg::HMP_IDLE;
            end
        end
        if (commitWrite) begin
            {addrD, halfD} = nextPos;
            if (!pm_q) begin
                memReqD = 1'b1;
                memWeD = 1'b1;
                memPmD = 1'b0;
                memAddrD = addr_q;
                memWdataD = {8'h00, wrData_q};
                if (isOvl) begin
                    overlayD = wrData_q;
                end
            end else if (!half_q) begin
                pmHighD = wrData_q;
            end else begin
                memReqD = 1'b1;
                memWeD = 1'b1;
                memPmD = 1'b1;
                memAddrD = addr_q;
                memWdataD = {pmHigh_q, wrData_q[7:0]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_q <= hmp_pkg::HMP_IDLE;
            cnt_q <= 2'd0;
            ackN_q <= 1'b0;
            busOut_q <= 16'h0000;
            busOe_q <= 1'b0;
            prev_q <= 16'h0000;
            addr_q <= 14'h0000;
            pm_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            state_q <= stateD;
            cnt_q <= cntD;
            ackN_q <= ackND;
            busOut_q <= outD;
            busOe_q <= oeD;
            prev_q <= prevD;
            addr_q <= addrD;
            pm_q <= pmD;
            half_q <= halfD;
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pmLow_q <= 8'h00;
            pmHigh_q <= 16'h0000;
            wrData_q <= 16'h0000;
            overlay_q <= `HMP_OVERLAY_RST;
            memReq_q <= 1'b0;
            memWe_q <= 1'b0;
            memPm_q <= 1'b0;
            memAddr_q <= 14'h0000;
            memWdata_q <= 24'h000000;
            modeOut_q <= 1'b0;
        end else begin
            pmLow_q <= pmLowD;
            pmHigh_q <= pmHighD;
            wrData_q <= wrDataD;
            overlay_q <= overlayD;
            memReq_q <= memReqD;
            memWe_q <= memWeD;
            memPm_q <= memPmD;
            memAddr_q <= memAddrD;
            memWdata_q <= memWdataD;
            modeOut_q <= modeC;
        end
    end

    assign port_addr_data_bus_out = busOut_q;
    assign port_addr_data_bus_oe = busOe_q;
    assign port_acknowledge_n = ackN_q;
    assign hostPortMode = modeOut_q;
    assign overlayValue = overlay_q;
    assign memReq = memReq_q;
    assign memWe = memWe_q;
    assign memPm = memPm_q;
    assign memAddr = memAddr_q;
    assign memWdata = memWdata_q;

    default clocking hmpCb @(posedge mclk);
    endclocking
    default disable iff (!rstSyncN);

    sequence readStartSeq;
        readBegin && !isPm2;
    endsequence

    sequence writeStartSeq;
        writeBegin;
    endsequence

    ack_busy_read_a: assert property (readBegin |-> ##[1:ACK_BUSY_CYC] ackN_q)
        else $error("acknowledge not high after read start");
    bus_release_a: assert property (
        (busOe_q && !readActive) |-> ##[1:RELEASE_CYC] !busOe_q)
        else $error("bus not released after read end");
    prev_hold_a: assert property (readStartSeq |=> ##1 $stable(busOut_q) [*2])
        else $error("previous word not held for two clocks");
    sro_steady_a: assert property (
        (busOe_q && $past(busOe_q) && shortOnly && $past(shortOnly)) |-> $stable(busOut_q))
        else $error("word changed during short-read-only read");
    data_leads_ack_a: assert property (
        (state_q == hmp_pkg::HMP_RNEW) |-> ackN_q ##1 !ackN_q)
        else $error("acknowledge not low one clock after new data");
    write_ack_min_a: assert property (writeStartSeq |=> ackN_q [*2])
        else $error("write acknowledge low too early");
    host_ovl_write_a: assert property (
        (commitWrite && isOvl && !coreRegWe) |=> overlay_q == $past(wrData_q))
        else $error("host write to overlay register lost");
    mode_gate_a: assert property (!modeC |=> !busOe_q && !ackN_q)
        else $error("port active with mode strap clear");
    addr_step_a: assert property (
        (fetchDone && !(pm_q && !half_q) && !latchAddr) |=> addr_q == $past(addr_q) + 14'h0001)
        else $error("address not advanced after word");
endmodule

//--- design/hmp_reset_sync.sv
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module hmp_reset_sync (
    input wire logic mclk,
    input wire logic rst_n,
    output logic rstSyncN
);
    logic stage1_q;
    logic stage2_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign rstSyncN = stage2_q;
endmodule

//--- design/hmp_strap_latch.sv
// Captures the mode strap at the first edge after reset release
`timescale 1ns/1ps
module hmp_strap_latch (
    input wire logic mclk,
    input wire logic rstSyncN,
    input wire logic strapPin,
    output logic strapMode
);
    logic done_q;
    logic mode_q;

    // Sample once after release, then hold
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            done_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (!done_q) begin
            done_q <= 1'b1;
            mode_q <= strapPin;
        end
    end

    assign strapMode = mode_q;
endmodule
